//--- src/dcf_fifo_top.sv
`timescale 1ns/100ps
// Function
// R01: Space flag high while store not full, low when full.
// R02: In reset space flag drops at 2nd write edge; rises 2nd edge after.
// R03: After full, space flag rises on 2nd write edge after first read.
// R04: Output word pins float whenever drive enable is low.
// R05: Reader raises drive enable before any edge meant to remove a word.
// R06: Valid flag high while store not empty, low when empty.
// R07: In reset valid flag drops at third read clock edge.
// R08: Valid flag rises at third read edge after first write to empty store.
// R09: Valid flag drops at first read edge after last word is read.
// R10: First word appears at third read edge, ignoring read enables.
// R11: Later words advance only with both enables, drive enable, valid high.
// R12: Read clock free running; outgoing transfers and valid flag follow it.
// R13: Reset clears pointers, half and space and valid low, near-limit high.
// R14: Controller resets the device after power-up before trusting it.
// R15: Strobe low at reset release selects previously captured offset.
// R16: Strobe high at reset release selects default offset 256.
// R17: Word stored only when space flag and both write enables high.
// R18: Write clock free running; incoming transfers and space flag follow it.
// R19: Offset capture independent of both write enables.
// R20: Offset is in_word bits 0 to 8, unsigned; upper bits ignored.
// R21: Half-level flag high at 513 or more words, low at 512 or fewer.
// R22: Near-limit high at or below offset+1 or at or above 1025-offset.
// R23: Falling strobe edge captures low nine input bits as new offset.
// R24: Store holds 1024 words of 18 bits; occupancy computed safely.
module dcf_fifo_top
  import dcf_pkg::*;
#(
  parameter int WIDTH = DCF_WIDTH,
  parameter int DEPTH = DCF_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DCF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic reset_n,
  input wire logic threshold_load_strobe,
  input wire logic write_enable_a,
  input wire logic write_enable_b,
  input wire logic read_enable_a,
  input wire logic read_enable_b,
  input wire logic output_drive_enable,
  input wire logic [WIDTH-1:0] in_word,
  output logic [WIDTH-1:0] out_word,
  output logic out_word_oe_n,
  output logic write_space_flag,
  output logic read_valid_flag,
  output logic half_level_flag,
  output logic near_limit_flag
);

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int PINS_W = WIDTH + 9;
  localparam logic [PW-1:0] FULL_COUNT = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_LEVEL = PW'(DEPTH / 2 + 1);
  localparam logic [PW-1:0] NEAR_TOP = PW'(DEPTH + 1);
  localparam logic [PW-1:0] ONE = PW'(1);

  logic [PINS_W-1:0] pins_s;
  logic [WIDTH-1:0] in_s;
  logic wclk_s, rclk_s, dev_rst_n_s, strobe_s;
  logic wea_s, web_s, rea_s, reb_s, oe_s;
  logic wclk_d, rclk_d, rst_d, strobe_d;
  logic wclk_rise, rclk_rise, strobe_fall, rst_release, rst_change;

  // Clock pins are sampled like data, so data and edges share latency
  dcf_sync #(.WIDTH(PINS_W)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d_async({in_word, write_clock, read_clock, reset_n, threshold_load_strobe,
              write_enable_a, write_enable_b, read_enable_a, read_enable_b,
              output_drive_enable}),
    .q_sync(pins_s)
  );

  assign {in_s, wclk_s, rclk_s, dev_rst_n_s, strobe_s, wea_s, web_s, rea_s, reb_s,
          oe_s} = pins_s;

  // Delayed copies for edge detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
      rst_d <= 1'b0;
      strobe_d <= 1'b0;
    end else begin
      wclk_d <= wclk_s;
      rclk_d <= rclk_s;
      rst_d <= dev_rst_n_s;
      strobe_d <= strobe_s;
    end
  end

  // Free-running pin clocks become one-cycle enables
  assign wclk_rise = wclk_s & ~wclk_d; // see R18
  assign rclk_rise = rclk_s & ~rclk_d; // see R12
  assign strobe_fall = strobe_d & ~strobe_s;
  assign rst_release = dev_rst_n_s & ~rst_d;
  assign rst_change = dev_rst_n_s ^ rst_d;

  // ****************************************************************
  // Storage and write side
  // ****************************************************************
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr_reg, rptr_reg, rptr_wv_reg, wptr_r1_reg, wptr_r2_reg;
  logic [PW-1:0] wptr_next, wfill_next;
  logic [1:0] wcnt_reg, rcnt_reg;
  logic space_reg, wr_fire;

  assign wr_fire = wclk_rise & dev_rst_n_s & space_reg & wea_s & web_s; // see R17
  assign wptr_next = wr_fire ? wptr_reg + ONE : wptr_reg;
  assign wfill_next = wptr_next - rptr_wv_reg;

  // Write pointer; any reset level clears it at once
  always_ff @(posedge clk) begin
    if (!rstn || !dev_rst_n_s) begin
      wptr_reg <= '0; // see R13
    end else begin
      wptr_reg <= wptr_next;
    end
  end

  // Word array, no reset needed
  always_ff @(posedge clk) begin
    if (wr_fire) begin
      mem[wptr_reg[AW-1:0]] <= in_s; // see R24
    end
  end

  // Write side view of the read pointer, one write edge late
  always_ff @(posedge clk) begin
    if (!rstn || !dev_rst_n_s) begin
      rptr_wv_reg <= '0;
    end else if (wclk_rise) begin
      rptr_wv_reg <= rptr_reg;
    end
  end

  // Write edges since the reset level last changed, saturating
  always_ff @(posedge clk) begin
    if (!rstn || rst_change) begin
      wcnt_reg <= '0;
    end else if (wclk_rise && wcnt_reg != DCF_CNT_MAX) begin
      wcnt_reg <= wcnt_reg + 2'h1;
    end
  end

  // Space flag; the stale read view delays release by one write edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      space_reg <= 1'b0;
    end else if (wclk_rise && !rst_change && wcnt_reg >= DCF_WR_EDGE_IDX) begin
      // A rise seen with a reset level change counts for neither phase
      space_reg <= dev_rst_n_s & (wfill_next != FULL_COUNT); // see R01 see R02 see R03
    end else if (wclk_rise && dev_rst_n_s && wfill_next == FULL_COUNT) begin
      space_reg <= 1'b0; // see R01
    end
  end

  // ****************************************************************
  // Read side
  // ****************************************************************
  logic valid_reg, rd_take, avail;
  logic [WIDTH-1:0] rd_word;

  assign avail = wptr_r2_reg != rptr_reg;
  assign rd_word = mem[rptr_reg[AW-1:0]];
  // First word loads without enables, later ones need all of them
  assign rd_take = rclk_rise & dev_rst_n_s &
                   (~valid_reg | (rea_s & reb_s & oe_s)); // see R10 see R11

  // Two-stage read view of the write pointer gives the third-edge load
  always_ff @(posedge clk) begin
    if (!rstn || !dev_rst_n_s) begin
      wptr_r1_reg <= '0;
      wptr_r2_reg <= '0;
    end else if (rclk_rise) begin
      wptr_r1_reg <= wptr_reg; // see R08
      wptr_r2_reg <= wptr_r1_reg;
    end
  end

  // Read pointer
  always_ff @(posedge clk) begin
    if (!rstn || !dev_rst_n_s) begin
      rptr_reg <= '0; // see R13
    end else if (rd_take && avail) begin
      rptr_reg <= rptr_reg + ONE;
    end
  end

  // Read edges since the reset level last changed
  always_ff @(posedge clk) begin
    if (!rstn || rst_change) begin
      rcnt_reg <= '0;
    end else if (rclk_rise && rcnt_reg != DCF_CNT_MAX) begin
      rcnt_reg <= rcnt_reg + 2'h1;
    end
  end

  // Output word register; address was written two read edges ago
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_word <= '0;
    end else if (rd_take && avail) begin
      out_word <= rd_word; // see R10 see R11
    end
  end

  // Valid flag follows the read clock only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      valid_reg <= 1'b0;
    end else if (rclk_rise && !dev_rst_n_s) begin
      if (rcnt_reg >= DCF_RD_EDGE_IDX && !rst_change) begin
        valid_reg <= 1'b0; // see R07
      end
    end else if (rd_take) begin
      valid_reg <= avail; // see R06 see R08 see R09 see R12
    end
  end

  // Drive enable registered and inverted; a drive enable of zero means high impedance
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_word_oe_n <= 1'b1;
    end else begin
      out_word_oe_n <= ~oe_s; // see R04
    end
  end

  // ****************************************************************
  // Level flags and near-limit offset
  // ****************************************************************
  logic [PW-1:0] occ, near_lo, near_hi;
  logic [DCF_OFF_W-1:0] offset_pend_reg, offset_act_reg;
  logic half_reg, near_reg;
  logic apb_setup, apb_done, offset_wr;

  // Single clock domain, so plain binary pointers subtract safely
  assign occ = wptr_reg - rptr_reg; // see R24
  assign near_lo = PW'(offset_act_reg) + ONE;
  assign near_hi = NEAR_TOP - PW'(offset_act_reg);

  // Pending offset; the write enables play no part in capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      offset_pend_reg <= DCF_DEFAULT_OFFSET;
    end else if (strobe_fall) begin
      offset_pend_reg <= in_s[DCF_OFF_W-1:0]; // see R19 see R20 see R23
    end else if (offset_wr) begin
      offset_pend_reg <= pwdata[DCF_OFF_W-1:0];
    end
  end

  // Active boundary chosen by the strobe level at reset release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      offset_act_reg <= DCF_DEFAULT_OFFSET;
    end else if (rst_release) begin
      offset_act_reg <= strobe_s ? DCF_DEFAULT_OFFSET : offset_pend_reg; // see R15 see R16
    end
  end

  // Half and near flags, forced to reset values during reset
  always_ff @(posedge clk) begin
    if (!rstn || !dev_rst_n_s) begin
      half_reg <= 1'b0; // see R13
      near_reg <= 1'b1;
    end else begin
      half_reg <= occ >= HALF_LEVEL; // see R21
      near_reg <= (occ <= near_lo) || (occ >= near_hi); // see R22
    end
  end

  assign write_space_flag = space_reg;
  assign read_valid_flag = valid_reg;
  assign half_level_flag = half_reg;
  assign near_limit_flag = near_reg;

  // ****************************************************************
  // APB slave: zero wait states, registered answer
  // ****************************************************************
  assign apb_setup = psel & ~penable;
  assign apb_done = psel & penable & pready;
  assign offset_wr = apb_done & pwrite & (paddr == DCF_REG_OFFSET);

  // Ready and read data prepared in the setup cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= '0;
      if (apb_setup) begin
        unique case (paddr)
          DCF_REG_STATUS: prdata <= {{DCF_STATUS_PAD{1'b0}}, near_reg, half_reg,
                                     valid_reg, space_reg};
          DCF_REG_OFFSET: prdata <= {{DCF_OFFSET_PAD{1'b0}}, offset_act_reg,
                                     {DCF_OFFSET_PAD{1'b0}}, offset_pend_reg};
          DCF_REG_LEVEL: prdata <= {{(32 - PW){1'b0}}, occ};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_space_full;
    space_reg && dev_rst_n_s |-> (wptr_reg - rptr_wv_reg) != FULL_COUNT;
  endproperty
  a_space_full: assert property (p_space_full) else $error("space flag high while full"); // see R01

  property p_space_reset;
    wclk_rise && !dev_rst_n_s && !rst_change && wcnt_reg >= DCF_WR_EDGE_IDX |=> !space_reg;
  endproperty
  a_space_reset: assert property (p_space_reset) else $error("space flag not low in reset"); // see R02

  property p_space_release;
    wclk_rise && dev_rst_n_s && !rst_change && wcnt_reg == 2'h0 && !space_reg
      |=> !space_reg;
  endproperty
  a_space_release: assert property (p_space_release) else $error("space flag rose early"); // see R02

  property p_hiz;
    !oe_s |=> out_word_oe_n ##1 (out_word_oe_n || $past(oe_s));
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven with drive enable low"); // see R04

  property p_valid_reset;
    rclk_rise && !dev_rst_n_s && !rst_change && rcnt_reg >= DCF_RD_EDGE_IDX |=> !valid_reg;
  endproperty
  a_valid_reset: assert property (p_valid_reset) else $error("valid flag not low in reset"); // see R07

  property p_first_word;
    rclk_rise && dev_rst_n_s && !valid_reg && avail
      |=> valid_reg && out_word == $past(rd_word);
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word not presented"); // see R10

  property p_empty;
    rd_take && valid_reg && !avail |=> !valid_reg;
  endproperty
  a_empty: assert property (p_empty) else $error("valid flag stayed high when empty"); // see R09

  property p_hold;
    rclk_rise && dev_rst_n_s && valid_reg && !(rea_s && reb_s && oe_s)
      |=> $stable(out_word) && $stable(rptr_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("word advanced without enables"); // see R11

  property p_write_gate;
    dev_rst_n_s && $changed(wptr_reg) |-> $past(wclk_rise && space_reg && wea_s && web_s);
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("write without enables"); // see R17

  property p_half;
    dev_rst_n_s && $past(dev_rst_n_s) |-> half_reg == ($past(occ) >= HALF_LEVEL);
  endproperty
  a_half: assert property (p_half) else $error("half flag wrong"); // see R21

  property p_near;
    dev_rst_n_s && $past(dev_rst_n_s)
      |-> near_reg == ($past(occ) <= $past(near_lo) || $past(occ) >= $past(near_hi));
  endproperty
  a_near: assert property (p_near) else $error("near limit flag wrong"); // see R22

  property p_default_off;
    rst_release && strobe_s |=> offset_act_reg == DCF_DEFAULT_OFFSET;
  endproperty
  a_default_off: assert property (p_default_off) else $error("default offset not used"); // see R16

  property p_user_off;
    rst_release && !strobe_s |=> offset_act_reg == $past(offset_pend_reg);
  endproperty
  a_user_off: assert property (p_user_off) else $error("captured offset not used"); // see R15

  property p_capture;
    strobe_fall |=> offset_pend_reg == $past(in_s[DCF_OFF_W-1:0]);
  endproperty
  a_capture: assert property (p_capture) else $error("offset not captured"); // see R23

endmodule // dcf_fifo_top

//--- src/dcf_pkg.sv
// ****************************************************************
// Shared constants of the dual clock word store
// ****************************************************************
package dcf_pkg;

  // Store geometry
  localparam int DCF_WIDTH = 18;
  localparam int DCF_DEPTH = 1024;
  localparam int DCF_OFF_W = 9;

  // Near-limit offset used when the strobe is high at reset release
  localparam logic [8:0] DCF_DEFAULT_OFFSET = 9'h100;

  // Edge counters: index of the edge (zero based) that acts
  localparam logic [1:0] DCF_WR_EDGE_IDX = 2'h1;
  localparam logic [1:0] DCF_RD_EDGE_IDX = 2'h2;
  localparam logic [1:0] DCF_CNT_MAX = 2'h3;

  // APB register map, byte addresses
  localparam int DCF_ADDR_W = 8;
  localparam logic [7:0] DCF_REG_STATUS = 8'h00;
  localparam logic [7:0] DCF_REG_OFFSET = 8'h04;
  localparam logic [7:0] DCF_REG_LEVEL = 8'h08;

  // Field padding widths in the read words
  localparam int DCF_STATUS_PAD = 28;
  localparam int DCF_OFFSET_PAD = 7;

endpackage

//--- src/dcf_sync.sv
`timescale 1ns/100ps
// ****************************************************************
// Two flip-flop synchroniser for pin inputs
// ****************************************************************
module dcf_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d_async,
  output logic [WIDTH-1:0] q_sync
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= '0;
      q_sync <= '0;
    end else begin
      meta_reg <= d_async;
      q_sync <= meta_reg;
    end
  end

endmodule // dcf_sync

//--- verification/dcf_far_model.sv
`timescale 1ns/100ps
// ****************************************
// Pin side writer and reader
// ****************************************
module dcf_far_model
  import dcf_pkg::*;
(
  output logic write_clock,
  output logic read_clock,
  output logic reset_n,
  output logic threshold_load_strobe,
  output logic write_enable_a,
  output logic write_enable_b,
  output logic read_enable_a,
  output logic read_enable_b,
  output logic output_drive_enable,
  output logic [DCF_WIDTH-1:0] in_word,
  input wire logic [DCF_WIDTH-1:0] out_word,
  input wire logic write_space_flag,
  input wire logic read_valid_flag
);
  // Free running clocks, periods unrelated so phases drift
  initial begin
    write_clock = 1'b0;
    forever #20 write_clock = ~write_clock;
  end
  initial begin
    read_clock = 1'b0;
    #7;
    forever #22.5 read_clock = ~read_clock;
  end
  // Power up with reset held and every enable off
  initial begin
    reset_n = 1'b0;
    threshold_load_strobe = 1'b1;
    write_enable_a = 1'b0;
    write_enable_b = 1'b0;
    read_enable_a = 1'b0;
    read_enable_b = 1'b0;
    output_drive_enable = 1'b0;
    in_word = 18'h0;
  end
  // Reset level; strobe level chosen before release
  task automatic reset_begin(input logic strobe);
    @(negedge write_clock);
    threshold_load_strobe = strobe;
    reset_n = 1'b0;
  endtask
  task automatic reset_end();
    @(negedge read_clock);
    reset_n = 1'b1;
  endtask
  // Offset capture while write enables stay low
  task automatic load_offset(input logic [DCF_WIDTH-1:0] d);
    @(negedge write_clock);
    in_word = d;
    threshold_load_strobe = 1'b1;
    repeat (2) @(negedge write_clock);
    threshold_load_strobe = 1'b0;
    repeat (2) @(negedge write_clock);
    in_word = ~d;  // Released lines toggle so stale data never looks valid
  endtask
  // One write edge; en drives each write enable alone; acc says whether there was space
  task automatic wr(input logic [1:0] en, input logic [DCF_WIDTH-1:0] d,
                    output logic acc);
    @(negedge write_clock);
    in_word = d;
    write_enable_a = en[0];
    write_enable_b = en[1];
    @(posedge write_clock);
    acc = write_space_flag;
  endtask
  task automatic wr_stop();
    @(negedge write_clock);
    write_enable_a = 1'b0;
    write_enable_b = 1'b0;
    in_word = ~in_word;
  endtask
  // One read edge; en is drive enable then read enables
  task automatic rd(input logic [1:0] en, output logic [DCF_WIDTH-1:0] w, output logic v);
    @(negedge read_clock);
    output_drive_enable = en[1];
    read_enable_a = en[0];
    read_enable_b = en[0];
    @(posedge read_clock);
    v = read_valid_flag;
    w = out_word;
  endtask
endmodule  // dcf_far_model

//--- verification/tb.sv
`timescale 1ns/100ps
module tb
  import dcf_pkg::*;
;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [DCF_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic write_clock, read_clock, reset_n, threshold_load_strobe;
  logic write_enable_a, write_enable_b, read_enable_a, read_enable_b, output_drive_enable;
  logic [DCF_WIDTH-1:0] in_word, out_word;
  logic out_word_oe_n, write_space_flag, read_valid_flag, half_level_flag, near_limit_flag;
  logic [DCF_WIDTH-1:0] sb[$];
  int errors, n_tests, cyc;

  dcf_fifo_top u_dcf_fifo_top (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_clock(write_clock), .read_clock(read_clock), .reset_n(reset_n),
    .threshold_load_strobe(threshold_load_strobe), .write_enable_a(write_enable_a),
    .write_enable_b(write_enable_b), .read_enable_a(read_enable_a),
    .read_enable_b(read_enable_b), .output_drive_enable(output_drive_enable),
    .in_word(in_word), .out_word(out_word), .out_word_oe_n(out_word_oe_n),
    .write_space_flag(write_space_flag), .read_valid_flag(read_valid_flag),
    .half_level_flag(half_level_flag), .near_limit_flag(near_limit_flag)
  );
  dcf_far_model u_dcf_far_model (
    .write_clock(write_clock), .read_clock(read_clock), .reset_n(reset_n),
    .threshold_load_strobe(threshold_load_strobe), .write_enable_a(write_enable_a),
    .write_enable_b(write_enable_b), .read_enable_a(read_enable_a),
    .read_enable_b(read_enable_b), .output_drive_enable(output_drive_enable),
    .in_word(in_word), .out_word(out_word), .write_space_flag(write_space_flag),
    .read_valid_flag(read_valid_flag)
  );

  // ****************************************
  // Clock, timeout and reporting
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is about 20000 cycles; twice that means a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ****************************************
  // Register bus and pin helpers
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d & m, exp);
  endtask
  // Reads n words in order against the scoreboard, then parks the reader
  task automatic drain(input int n);
    logic [DCF_WIDTH-1:0] w;
    logic v;
    repeat (n) begin
      u_dcf_far_model.rd(2'b11, w, v);
      chk({13'h0, v, w}, {13'h0, 1'b1, sb.pop_front()});
    end
    u_dcf_far_model.rd(2'b00, w, v);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    u_dcf_far_model.reset_begin(1'b1);
    repeat (5) @(posedge read_clock);
    rreg(DCF_REG_STATUS, 32'hF, 32'h8);
    rreg(DCF_REG_LEVEL, 32'h7FF, 32'h0);
    u_dcf_far_model.reset_end();
    repeat (3) @(posedge write_clock);
    rreg(DCF_REG_STATUS, 32'hF, 32'h9);
    rreg(DCF_REG_OFFSET, 32'h01FF_0000, 32'h0100_0000);
    $display("test reset done");
  endtask
  task automatic t_offset();
    logic [31:0] d;
    logic e;
    logic acc;
    apb(1'b1, DCF_REG_OFFSET, 32'h0000_0123, d, e);
    rreg(DCF_REG_OFFSET, 32'h01FF_01FF, 32'h0100_0123);
    apb(1'b1, DCF_REG_STATUS, 32'hFFFF_FFFF, d, e);
    rreg(DCF_REG_STATUS, 32'hF, 32'h9);
    apb(1'b0, 8'h0C, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1);
    u_dcf_far_model.load_offset(18'h3FE05);
    rreg(DCF_REG_OFFSET, 32'h01FF_01FF, 32'h0100_0005);
    u_dcf_far_model.wr(2'b01, 18'h00011, acc);
    u_dcf_far_model.wr(2'b10, 18'h00022, acc);
    u_dcf_far_model.wr_stop();
    rreg(DCF_REG_LEVEL, 32'h7FF, 32'h0);
    u_dcf_far_model.reset_begin(1'b0);
    repeat (6) @(posedge read_clock);
    u_dcf_far_model.reset_end();
    repeat (3) @(posedge write_clock);
    rreg(DCF_REG_OFFSET, 32'h01FF_0000, 32'h0005_0000);
    $display("test offset done");
  endtask
  task automatic t_stream();
    logic [DCF_WIDTH-1:0] w;
    logic v, acc;
    u_dcf_far_model.wr(2'b11, 18'h2A5A5, acc);
    fork
      u_dcf_far_model.wr_stop();
    join_none
    sb.push_back(18'h2A5A5);
    // Count read edges only once the write is surely stored
    repeat (3) @(posedge clk);
    @(posedge read_clock);
    repeat (5) @(posedge clk);
    chk(32'(read_valid_flag), 32'h0);
    repeat (2) @(posedge read_clock);
    repeat (5) @(posedge clk);
    chk({13'h0, read_valid_flag, out_word}, {13'h0, 1'b1, sb[0]});
    chk(32'(out_word_oe_n), 32'h1);
    u_dcf_far_model.wr(2'b11, 18'h15A5A, acc);
    sb.push_back(18'h15A5A);
    u_dcf_far_model.wr(2'b11, 18'h0FFFF, acc);
    sb.push_back(18'h0FFFF);
    u_dcf_far_model.wr_stop();
    u_dcf_far_model.rd(2'b10, w, v);
    repeat (5) @(posedge clk);
    chk({13'h0, out_word_oe_n, out_word}, {13'h0, 1'b0, sb[0]});
    drain(3);
    chk(32'(read_valid_flag), 32'h0);
    $display("test stream done");
  endtask
  // Device reset while a word is presented; strobe stays low so offset 5 survives
  task automatic t_midreset();
    logic acc;
    u_dcf_far_model.wr(2'b11, 18'h3C3C3, acc);
    u_dcf_far_model.wr_stop();
    repeat (4) @(posedge read_clock);
    rreg(DCF_REG_STATUS, 32'hF, 32'hB);
    u_dcf_far_model.reset_begin(1'b0);
    repeat (2) @(posedge read_clock);
    rreg(DCF_REG_STATUS, 32'hE, 32'hA);
    repeat (2) @(posedge read_clock);
    rreg(DCF_REG_STATUS, 32'hF, 32'h8);
    rreg(DCF_REG_LEVEL, 32'h7FF, 32'h0);
    u_dcf_far_model.reset_end();
    repeat (3) @(posedge write_clock);
    rreg(DCF_REG_OFFSET, 32'h01FF_0000, 32'h0005_0000);
    rreg(DCF_REG_STATUS, 32'hF, 32'h9);
    $display("test midreset done");
  endtask
  task automatic t_fill();
    logic acc;
    for (int i = 0; i < 1030; i++) begin
      u_dcf_far_model.wr(2'b11, 18'(i) ^ 18'h2D2D2, acc);
      if (acc) sb.push_back(18'(i) ^ 18'h2D2D2);
      if (i == 200) chk({30'h0, half_level_flag, near_limit_flag}, 32'h0);
    end
    u_dcf_far_model.wr_stop();
    rreg(DCF_REG_LEVEL, 32'h7FF, 32'h400);
    rreg(DCF_REG_STATUS, 32'hF, 32'hE);
    drain(1);
    repeat (2) @(posedge write_clock);
    repeat (5) @(posedge clk);
    chk(32'(write_space_flag), 32'h1);
    drain(sb.size());
    rreg(DCF_REG_STATUS, 32'hF, 32'h9);
    $display("test fill done");
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_offset();
    t_stream();
    t_midreset();
    t_fill();
    results();
  end
endmodule  // tb
